// [hw/acc_regs.svh]
// Purpose: Register offsets, field positions and timing counts for the
//          converter channel and conversion control block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Only the low eight bits of CTRL, six of SEL and three of TRIG are implemented.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ACC_OFF_CTRL 12'h018
`define ACC_OFF_SEL 12'h01c
`define ACC_OFF_TRIG 12'h00c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ACC_B_EN 7
`define ACC_B_START 6
`define ACC_B_AUTO 5
`define ACC_B_DONE 4
`define ACC_B_IE 3
`define ACC_CTRL_RST 8'h00

// ----------------------------------------------------------------------
// Selection code landmarks
// ----------------------------------------------------------------------
`define ACC_SEL_GND 6'h20
`define ACC_SEL_VREF 6'h21
`define ACC_SEL_TEMP 6'h22
`define ACC_TRIG_FREE 3'h0

// ----------------------------------------------------------------------
// Conversion lengths in converter clocks
// ----------------------------------------------------------------------
`define ACC_CONV_FIRST 5'h19
`define ACC_CONV_NORM 5'h0d

`endif

// [hw/acc_pkg.sv]
// Purpose: Types for the converter control block.
// Assumes: Constants live in acc_regs.svh.
// Notes:   One-hot state codes are written out.
package acc_pkg;

   // Converter sequencing states
   typedef enum logic [2:0] {
      ACC_IDLE = 3'h1,
      ACC_CONV = 3'h2,
      ACC_DONE = 3'h4
   } acc_state_e;

   // Kind of analog selection driven to the front end
   typedef enum logic [1:0] {
      ACC_K_SINGLE = 2'h0,
      ACC_K_DIFF = 2'h1,
      ACC_K_CAL = 2'h2,
      ACC_K_INT = 2'h3
   } acc_kind_e;

   // Whole state of the block
   typedef struct packed {
      acc_state_e st;
      logic en;
      logic auto_en;
      logic done;
      logic ie;
      logic [2:0] div_sel;
      logic [5:0] sel_sw;
      logic [5:0] sel_act;
      logic [2:0] trig_src;
      logic first;
      logic [6:0] pre_cnt;
      logic [4:0] cyc_cnt;
      logic [2:0] trig_sync;
      logic trig_prev;
      logic start_conv;
      logic [31:0] prdata;
      logic pready;
      logic irq;
      logic [3:0] pos_in;
      logic [3:0] neg_in;
      logic gain20;
      acc_kind_e kind;
   } acc_state_s;

endpackage

// [hw/acc_ctrl.sv]
// Purpose: Channel decode and conversion sequencing for the converter.
// Assumes: APB master; trigger input from another domain; one clock.
// Notes:   Result formatting and reference selection live elsewhere.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_ctrl (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_in,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic conv_irq,
   output logic converter_enable,
   output logic conv_start,
   output logic [3:0] pos_input,
   output logic [3:0] neg_input,
   output logic gain_twenty,
   output logic [1:0] input_kind
);

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   acc_pkg::acc_state_s s_r; // Registered state
   acc_pkg::acc_state_s s_nxt; // Next state
   logic wr_acc; // APB write access phase
   logic rd_acc; // APB read access phase
   logic tick; // Converter clock enable
   logic [6:0] div_top; // Prescaler terminal count
   logic trig_rise; // Filtered trigger edge
   logic [7:0] ctrl_view; // Control register as read
   logic [5:0] c; // Code being decoded

   // The access phase is taken once; the cycle that shows pready is
   // masked so that a held request cannot act twice. Only the bus
   // decode is masked, so the sequencer, the prescaler and the vector
   // clear keep running while the bus answers.
   assign wr_acc = psel & penable & pwrite & ~s_r.pready;
   assign rd_acc = psel & penable & ~pwrite & ~s_r.pready;

   // --------------------------------------------------------------------
   // Prescaler terminal count
   // --------------------------------------------------------------------
   // Codes 0 and 1 both divide by two
   always_comb begin
      case (s_r.div_sel)
         3'h0, 3'h1: div_top = 7'h01;
         3'h2: div_top = 7'h03;
         3'h3: div_top = 7'h07;
         3'h4: div_top = 7'h0f;
         3'h5: div_top = 7'h1f;
         3'h6: div_top = 7'h3f;
         default: div_top = 7'h7f;
      endcase
   end

   assign tick = (s_r.pre_cnt == div_top);
   // Stages two and three must agree before an edge counts
   assign trig_rise = (s_r.trig_sync[2] == s_r.trig_sync[1]) &
                      s_r.trig_sync[1] & ~s_r.trig_prev;
   assign ctrl_view = {s_r.en, s_r.st != acc_pkg::ACC_IDLE, s_r.auto_en,
                       s_r.done, s_r.ie, s_r.div_sel};

   // --------------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      c = 6'h00;
      s_nxt.pready = 1'b0;
      s_nxt.start_conv = 1'b0;
      s_nxt.trig_sync = {s_r.trig_sync[1:0], trigger_in};
      // Filtered level tracks only when the late stages agree
      if (s_r.trig_sync[2] == s_r.trig_sync[1]) begin
         s_nxt.trig_prev = s_r.trig_sync[1];
      end
      // Prescaler free-runs only while enabled, saving power when off
      if (!s_r.en || tick) begin
         s_nxt.pre_cnt = 7'h00;
      end else begin
         s_nxt.pre_cnt = s_r.pre_cnt + 7'h01;
      end

      // Sequencer
      case (s_r.st)
         acc_pkg::ACC_IDLE: begin
            // Free mode ignores edges, so a code switch makes no event
            if (s_r.en && s_r.auto_en && trig_rise &&
                s_r.trig_src != `ACC_TRIG_FREE) begin
               s_nxt.st = acc_pkg::ACC_CONV;
               s_nxt.start_conv = 1'b1;
               s_nxt.cyc_cnt = 5'h00;
               s_nxt.sel_act = s_r.sel_sw;
            end
         end
         acc_pkg::ACC_CONV: begin
            if (tick) begin
               s_nxt.cyc_cnt = s_r.cyc_cnt + 5'h01;
               if (s_r.cyc_cnt + 5'h01 == (s_r.first ? `ACC_CONV_FIRST
                                                     : `ACC_CONV_NORM)) begin
                  s_nxt.st = acc_pkg::ACC_DONE;
                  s_nxt.first = 1'b0;
               end
            end
         end
         acc_pkg::ACC_DONE: begin
            s_nxt.done = 1'b1;
            s_nxt.sel_act = s_r.sel_sw;
            if (s_r.auto_en && s_r.trig_src == `ACC_TRIG_FREE) begin
               s_nxt.st = acc_pkg::ACC_CONV;
               s_nxt.start_conv = 1'b1;
               s_nxt.cyc_cnt = 5'h00;
            end else begin
               s_nxt.st = acc_pkg::ACC_IDLE;
            end
         end
         default: s_nxt.st = acc_pkg::ACC_IDLE;
      endcase

      // Vector taken clears the flag; set in the same cycle still wins
      if (irq_vector_ack && s_r.st != acc_pkg::ACC_DONE) begin
         s_nxt.done = 1'b0;
      end

      // Register writes
      if (wr_acc) begin
         s_nxt.pready = 1'b1;
         if (paddr == `ACC_OFF_CTRL) begin
            s_nxt.en = pwdata[`ACC_B_EN];
            s_nxt.auto_en = pwdata[`ACC_B_AUTO];
            s_nxt.ie = pwdata[`ACC_B_IE];
            s_nxt.div_sel = pwdata[2:0];
            // Write-one clears; a completing conversion keeps it set
            if (pwdata[`ACC_B_DONE] && s_r.st != acc_pkg::ACC_DONE) begin
               s_nxt.done = 1'b0;
            end
            if (!pwdata[`ACC_B_EN]) begin
               s_nxt.st = acc_pkg::ACC_IDLE;
               // A trigger start in this same cycle is dropped too
               s_nxt.start_conv = 1'b0;
               s_nxt.first = 1'b1;
               s_nxt.pre_cnt = 7'h00;
            end else if (!s_r.en) begin
               s_nxt.first = 1'b1;
            end
            // Zero on the start bit is ignored
            if (pwdata[`ACC_B_EN] && pwdata[`ACC_B_START] &&
                s_r.st == acc_pkg::ACC_IDLE) begin
               s_nxt.st = acc_pkg::ACC_CONV;
               s_nxt.start_conv = 1'b1;
               s_nxt.cyc_cnt = 5'h00;
               s_nxt.sel_act = s_r.sel_sw;
               s_nxt.pre_cnt = 7'h00;
            end
         end else if (paddr == `ACC_OFF_SEL) begin
            s_nxt.sel_sw = pwdata[5:0];
            // Idle converter takes the new selection at once
            if (s_r.st == acc_pkg::ACC_IDLE) begin
               s_nxt.sel_act = pwdata[5:0];
            end
         end else if (paddr == `ACC_OFF_TRIG) begin
            s_nxt.trig_src = pwdata[2:0];
         end
      end

      // Register reads
      if (rd_acc) begin
         s_nxt.pready = 1'b1;
         if (paddr == `ACC_OFF_CTRL) begin
            s_nxt.prdata = {24'h000000, ctrl_view};
         end else if (paddr == `ACC_OFF_SEL) begin
            s_nxt.prdata = {26'h0000000, s_r.sel_sw};
         end else if (paddr == `ACC_OFF_TRIG) begin
            s_nxt.prdata = {29'h00000000, s_r.trig_src};
         end else begin
            s_nxt.prdata = 32'h00000000;
         end
      end
      s_nxt.irq = s_nxt.done & s_nxt.ie & global_irq_enable;

      // Channel decode of the active selection
      c = s_nxt.sel_act;
      s_nxt.gain20 = 1'b0;
      s_nxt.pos_in = {1'b0, c[2:0]};
      s_nxt.neg_in = {1'b0, c[2:0]};
      s_nxt.kind = acc_pkg::ACC_K_SINGLE;
      if (c[5:3] == 3'h0) begin
         s_nxt.kind = acc_pkg::ACC_K_SINGLE;
      end else if (c == `ACC_SEL_GND || c == `ACC_SEL_VREF ||
                   c == `ACC_SEL_TEMP) begin
         s_nxt.kind = acc_pkg::ACC_K_INT;
         s_nxt.pos_in = {2'h2, c[1:0]};
         s_nxt.neg_in = {2'h2, c[1:0]};
      end else if (c[5:3] == 3'h4) begin
         // Codes 100011 give input 0, 10010x input 3, 10011x input 7
         s_nxt.kind = acc_pkg::ACC_K_CAL;
         s_nxt.gain20 = c[0] | (c[2:1] == 2'h1);
         case (c[2:1])
            2'h1: s_nxt.pos_in = 4'h0;
            2'h2: s_nxt.pos_in = 4'h3;
            default: s_nxt.pos_in = 4'h7;
         endcase
         s_nxt.neg_in = s_nxt.pos_in;
      end else begin
         s_nxt.kind = acc_pkg::ACC_K_DIFF;
         s_nxt.gain20 = c[0];
         // Normal pair table indexed by code bits 4:1
         case ({1'b0, c[4:1]})
            5'h04: {s_nxt.pos_in, s_nxt.neg_in} = 8'h01;
            5'h05: {s_nxt.pos_in, s_nxt.neg_in} = 8'h03;
            5'h06: {s_nxt.pos_in, s_nxt.neg_in} = 8'h12;
            5'h07: {s_nxt.pos_in, s_nxt.neg_in} = 8'h13;
            5'h08: {s_nxt.pos_in, s_nxt.neg_in} = 8'h23;
            5'h09: {s_nxt.pos_in, s_nxt.neg_in} = 8'h34;
            5'h0a: {s_nxt.pos_in, s_nxt.neg_in} = 8'h35;
            5'h0b: {s_nxt.pos_in, s_nxt.neg_in} = 8'h36;
            5'h0c: {s_nxt.pos_in, s_nxt.neg_in} = 8'h37;
            5'h0d: {s_nxt.pos_in, s_nxt.neg_in} = 8'h45;
            5'h0e: {s_nxt.pos_in, s_nxt.neg_in} = 8'h56;
            default: {s_nxt.pos_in, s_nxt.neg_in} = 8'h67;
         endcase
         // Reversed codes swap the two sides
         if (c[5]) begin
            {s_nxt.pos_in, s_nxt.neg_in} = {s_nxt.neg_in, s_nxt.pos_in};
         end
      end
   end

   // --------------------------------------------------------------------
   // State register
   // --------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
         s_r.st <= acc_pkg::ACC_IDLE;
         s_r.first <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = 1'b0;
   assign conv_irq = s_r.irq;
   assign converter_enable = s_r.en;
   assign conv_start = s_r.start_conv;
   assign pos_input = s_r.pos_in;
   assign neg_input = s_r.neg_in;
   assign gain_twenty = s_r.gain20;
   assign input_kind = s_r.kind;

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   a_irq_gating: assert property (@(posedge clk_sys) disable iff (!arst_n)
      conv_irq |-> s_r.done && s_r.ie) else $error("irq without cause");
   a_disable_abort: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !s_r.en |-> s_r.st == acc_pkg::ACC_IDLE) else $error("busy while off");
   a_done_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.st == acc_pkg::ACC_DONE |=> s_r.done) else $error("flag not set");
   a_cal_same: assert property (@(posedge clk_sys) disable iff (!arst_n)
      input_kind == acc_pkg::ACC_K_CAL |-> pos_input == neg_input)
      else $error("cal sides differ");
   a_gain_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      input_kind == acc_pkg::ACC_K_DIFF |-> gain_twenty == s_r.sel_act[0])
      else $error("gain mismatch");
   a_single_map: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.sel_act[5:3] == 3'h0 |-> pos_input == {1'b0, s_r.sel_act[2:0]})
      else $error("single map");
   a_free_restart: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.st == acc_pkg::ACC_DONE && s_r.auto_en && !s_r.pready &&
      s_r.trig_src == `ACC_TRIG_FREE |=> conv_start)
      else $error("no restart");
   a_start_conv: assert property (@(posedge clk_sys) disable iff (!arst_n)
      conv_start |-> s_r.st == acc_pkg::ACC_CONV && s_r.cyc_cnt == 5'h00)
      else $error("start w/o conv");

   // --------------------------------------------------------------------
   // Sequencing and decode checks
   // --------------------------------------------------------------------
   // Any pair code, normal or reversed, decodes as a pair
   a_pair_kind: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.sel_act[5:3] != 3'h0 && s_r.sel_act[5:3] != 3'h4 |->
      input_kind == acc_pkg::ACC_K_DIFF) else $error("pair kind");
   // The five codes above the internal ones are calibration only
   a_cal_kind: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.sel_act[5:3] == 3'h4 && s_r.sel_act[2:0] > 3'h2 |->
      input_kind == acc_pkg::ACC_K_CAL) else $error("cal kind");
   // Calibration is offered on three inputs only
   a_cal_inputs: assert property (@(posedge clk_sys) disable iff (!arst_n)
      input_kind == acc_pkg::ACC_K_CAL |->
      pos_input == 4'h0 || pos_input == 4'h3 || pos_input == 4'h7)
      else $error("cal input");
   // The tick counter never runs past the length of this conversion
   a_conv_len: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.st == acc_pkg::ACC_CONV |->
      s_r.cyc_cnt < (s_r.first ? `ACC_CONV_FIRST : `ACC_CONV_NORM))
      else $error("conv too long");
   // Turning the converter on arms the long first conversion
   a_en_first: assert property (@(posedge clk_sys) disable iff (!arst_n)
      wr_acc && paddr == `ACC_OFF_CTRL && pwdata[`ACC_B_EN] && !s_r.en
      |=> s_r.first) else $error("first not armed");
   // The smallest divider is two, so ticks never come back to back
   a_tick_alt: assert property (@(posedge clk_sys) disable iff (!arst_n)
      tick |=> !tick) else $error("tick too fast");
   // Vector taken outside the completing cycle leaves the flag clear
   a_vec_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
      irq_vector_ack && s_r.st != acc_pkg::ACC_DONE |=> !s_r.done)
      else $error("flag kept");
   // A qualified trigger edge while idle starts a conversion
   a_auto_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.st == acc_pkg::ACC_IDLE && s_r.en && s_r.auto_en && trig_rise &&
      s_r.trig_src != `ACC_TRIG_FREE && !wr_acc |=> conv_start)
      else $error("trigger lost");
   // Free mode never starts on its own from idle, flag set or not
   a_free_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.st == acc_pkg::ACC_IDLE && s_r.trig_src == `ACC_TRIG_FREE &&
      !wr_acc |=> !conv_start) else $error("free mode event");
   // The selection used by a running conversion does not move
   a_sel_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.st == acc_pkg::ACC_CONV |=> $stable(s_r.sel_act))
      else $error("selection moved");

endmodule

// [dv/acc_fe_model.sv]
// Purpose: Stand-in for the analog front end behind the control block.
// Assumes: Selection outputs are settled when the start pulse is seen.
// Notes:   Observes only; it never drives the control block.
`timescale 1ns/1ps

module acc_fe_model (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic conv_start,
   input wire logic [3:0] pos_input,
   output logic [15:0] n_starts,
   output logic [3:0] pos_seen
);
   // -------------------------------------------------
   // Sample and hold at each conversion start
   // -------------------------------------------------
   // The real sampler freezes its input here, so a selection change after
   // this point must not reach this conversion
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         n_starts <= 16'h0;
         pos_seen <= 4'h0;
      end else if (conv_start) begin
         n_starts <= n_starts + 16'h1;
         pos_seen <= pos_input;
      end
   end
endmodule

// [dv/adc_channel_and_conversion_control_test.sv]
// Purpose: Self-checking bench for the converter control block.
// Assumes: APB answers within a few cycles; ticks are prescaled clk_sys.
// Notes:   Conversion lengths are checked with slack for prescaler phase.
`timescale 1ns/1ps
`include "acc_regs.svh"
`define CHK(g,e) begin n_tests++; if ((g)!==(e)) begin bad_count++; \
$display("BAD %0t got %0h exp %0h", $time, g, e); end end

module adc_channel_and_conversion_control_test;
   // Design inputs, all valued at time zero
   logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic trigger_in = 0, global_irq_enable = 1, irq_vector_ack = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, conv_irq, converter_enable, conv_start;
   logic gain_twenty;
   logic [3:0] pos_input, neg_input, pos_seen;
   logic [1:0] input_kind;
   logic [15:0] n_starts, k;
   int bad_count = 0, n_tests = 0;

   acc_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_in(trigger_in), .global_irq_enable(global_irq_enable),
      .irq_vector_ack(irq_vector_ack), .conv_irq(conv_irq),
      .converter_enable(converter_enable), .conv_start(conv_start),
      .pos_input(pos_input), .neg_input(neg_input),
      .gain_twenty(gain_twenty), .input_kind(input_kind));
   acc_fe_model pm (.clk_sys(clk_sys), .arst_n(arst_n),
      .conv_start(conv_start), .pos_input(pos_input),
      .n_starts(n_starts), .pos_seen(pos_seen));

   // -------------------------------------------------
   // Clock and watchdog
   // -------------------------------------------------
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // Longest path is the divide-by-128 runs, well under this
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      tally_and_finish();
   end

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   // One APB transfer; request held until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      i = 0;
      // Read just after the edge, so this is the value at that edge
      do begin
         @(posedge clk_sys);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("BAD %0t apb no ready", $time);
      end
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   // Whole control word; interrupt enable always on
   function automatic logic [31:0] cv(input logic e, s, a, dn,
         input logic [2:0] dv);
      cv = {24'h0, e, s, a, dn, 1'b1, dv};
   endfunction
   // Full writes only, never read-modify-write of the flag
   task conv(input logic [2:0] dv, input int t);
      int n, div;
      div = (dv < 2) ? 2 : (1 << dv);
      apb(1, `ACC_OFF_CTRL, cv(1, 0, 0, 1, dv));
      apb(1, `ACC_OFF_CTRL, cv(1, 1, 0, 0, dv));
      n = 0;
      while (conv_start !== 1'b1 && n < 64) begin
         @(posedge clk_sys);
         n++;
      end
      n = 0;
      while (conv_irq !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK(n >= t * div - 2 && n <= t * div + div + 4, 1'b1)
   endtask
   task sel(input logic [5:0] c, input logic [1:0] kd,
         input logic [3:0] p, ng, input logic g);
      apb(1, `ACC_OFF_SEL, {26'h0, c});
      repeat (4) @(posedge clk_sys);
      `CHK({input_kind, pos_input}, {kd, p})
      // Single inputs repeat the positive input on the negative side, unchecked here
      if (kd == 2'h1 || kd == 2'h2) `CHK({neg_input, gain_twenty}, {ng, g})
      else if (kd == 2'h3) `CHK(neg_input, ng)
   endtask
   task tally_and_finish;
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1;
      apb(0, `ACC_OFF_CTRL, 0);
      `CHK(rd, 32'h0)
      apb(1, 12'h010, 32'hff);
      apb(0, 12'h010, 0);
      `CHK(rd, 32'h0)
      // Decoder: at least one case per code class
      sel(6'h05, 0, 5, 0, 0);
      sel(6'h20, 3, 8, 8, 0);
      sel(6'h21, 3, 9, 9, 0);
      sel(6'h22, 3, 10, 10, 0);
      sel(6'h08, 1, 0, 1, 0);
      sel(6'h09, 1, 0, 1, 1);
      sel(6'h1e, 1, 6, 7, 0);
      sel(6'h28, 1, 1, 0, 0);
      sel(6'h3f, 1, 7, 6, 1);
      sel(6'h23, 2, 0, 0, 1);
      sel(6'h24, 2, 3, 3, 0);
      sel(6'h27, 2, 7, 7, 1);
      // First conversion long, then every prescale code
      conv(0, 25);
      apb(0, `ACC_OFF_CTRL, 0);
      `CHK(rd[7:4], 4'h9)
      for (int d = 0; d < 8; d++) conv(d[2:0], 13);
      // Zero start write ignored, then abort by disabling
      apb(1, `ACC_OFF_CTRL, cv(1, 0, 0, 1, 7));
      apb(1, `ACC_OFF_CTRL, cv(1, 1, 0, 0, 7));
      repeat (30) @(posedge clk_sys);
      apb(1, `ACC_OFF_CTRL, cv(1, 0, 0, 0, 7));
      apb(0, `ACC_OFF_CTRL, 0);
      `CHK(rd[6], 1'b1)
      apb(1, `ACC_OFF_CTRL, cv(0, 0, 0, 0, 7));
      apb(0, `ACC_OFF_CTRL, 0);
      `CHK({converter_enable, rd[6]}, 2'b00)
      repeat (1800) @(posedge clk_sys);
      `CHK(conv_irq, 1'b0)
      conv(0, 25);
      // Interrupt gating and the two ways of clearing the flag
      global_irq_enable <= 0;
      repeat (3) @(posedge clk_sys);
      `CHK(conv_irq, 1'b0)
      global_irq_enable <= 1;
      repeat (3) @(posedge clk_sys);
      `CHK(conv_irq, 1'b1)
      irq_vector_ack <= 1;
      @(posedge clk_sys);
      irq_vector_ack <= 0;
      repeat (3) @(posedge clk_sys);
      `CHK(conv_irq, 1'b0)
      conv(0, 13);
      apb(1, `ACC_OFF_CTRL, cv(1, 0, 0, 1, 0));
      apb(0, `ACC_OFF_CTRL, 0);
      `CHK({conv_irq, rd[4]}, 2'b00)
      // Selection change mid-conversion waits for completion
      apb(1, `ACC_OFF_SEL, 32'h5);
      apb(1, `ACC_OFF_CTRL, cv(1, 1, 0, 0, 7));
      repeat (20) @(posedge clk_sys);
      apb(1, `ACC_OFF_SEL, 32'h6);
      repeat (10) @(posedge clk_sys);
      `CHK({pos_input, pos_seen}, 8'h55)
      for (int i = 0; i < 2000 && conv_irq !== 1'b1; i++)
         @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      `CHK(pos_input, 4'h6)
      // Free running keeps restarting
      apb(1, `ACC_OFF_TRIG, 32'h0);
      apb(1, `ACC_OFF_CTRL, cv(1, 0, 1, 1, 0));
      k = n_starts;
      apb(1, `ACC_OFF_CTRL, cv(1, 1, 1, 0, 0));
      repeat (200) @(posedge clk_sys);
      `CHK(n_starts - k >= 16'h3, 1'b1)
      apb(1, `ACC_OFF_CTRL, cv(0, 0, 1, 1, 0));
      // External trigger edge, then switch to free running
      apb(1, `ACC_OFF_TRIG, 32'h1);
      apb(1, `ACC_OFF_CTRL, cv(1, 0, 1, 1, 0));
      k = n_starts;
      repeat (10) @(posedge clk_sys);
      trigger_in <= 1;
      repeat (12) @(posedge clk_sys);
      `CHK(n_starts - k, 16'h1)
      repeat (80) @(posedge clk_sys);
      trigger_in <= 0;
      `CHK(conv_irq, 1'b1)
      k = n_starts;
      apb(1, `ACC_OFF_TRIG, 32'h0);
      repeat (20) @(posedge clk_sys);
      `CHK(n_starts, k)
      tally_and_finish();
   end
endmodule
